// ### digipot_pkg.sv
// shared constants and types of the wiper reset and load logic
// assumes one 200 MHz system clock and a serial engine in front
package digipot_pkg;

  // ------------------------------------------------------------------
  // geometry and wiper codes
  // ------------------------------------------------------------------
  localparam int NUM_POTS = 4;
  localparam int WIPER_W = 9;
  localparam logic [8:0] WIPER_ZERO = 9'h000;
  localparam logic [8:0] WIPER_FULL_8BIT = 9'h100;
  localparam logic [8:0] WIPER_FULL_7BIT = 9'h080;
  localparam logic [8:0] WIPER_MID_8BIT = 9'h080;
  localparam logic [8:0] WIPER_MID_7BIT = 9'h040;

  // ------------------------------------------------------------------
  // addresses of the serial memory map
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_VOL_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_VOL_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_NV_WIPER0 = 4'h2;
  localparam logic [3:0] ADDR_NV_WIPER1 = 4'h3;
  localparam logic [3:0] ADDR_TCON0 = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_VOL_WIPER2 = 4'h6;
  localparam logic [3:0] ADDR_VOL_WIPER3 = 4'h7;
  localparam logic [3:0] ADDR_NV_WIPER2 = 4'h8;
  localparam logic [3:0] ADDR_NV_WIPER3 = 4'h9;
  localparam logic [3:0] ADDR_TCON1 = 4'hA;

  // ------------------------------------------------------------------
  // reset values and status fields
  // ------------------------------------------------------------------
  localparam logic [8:0] TERMINAL_CONNECT_CONTROL_RST = 9'h1FF;
  localparam logic [8:0] STATUS_FIXED = 9'h182;
  localparam int STATUS_EEWA_POS = 4;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int EE_WRITE_TIME_NS = 5000;
  localparam int EE_WRITE_CYCLES = (EE_WRITE_TIME_NS * 1000) / CLK_PERIOD_PS;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {OP_WRITE, OP_INC, OP_DEC, OP_READ} op_type;
  typedef enum logic [1:0] {CS_IDLE, CS_NORMAL, CS_HIGH_V} cs_level_type;
  typedef enum logic [2:0] {K_VOL, K_NV, K_TERMINAL_CONNECT_CONTROL, K_STATUS, K_NONE} kind_type;

  typedef struct packed {
    op_type op;
    logic [3:0] addr;
    logic [8:0] data;
    logic hv;
  } serial_cmd_type;

  typedef struct packed {
    logic cs;
    logic sck;
    logic sdi;
    logic wp;
  } pin_level_type;

  typedef struct packed {
    kind_type kind;
    logic [1:0] idx;
  } decode_type;

endpackage

// ### digipot_reset_wiper_load.sv
// reset, power sequencing and wiper reload of a quad digital pot
// assumes commands arrive decoded from a serial engine, one per cycle
//
// How it works
// RULE1: wiper code zero connects the wiper to terminal B.
// RULE2: full scale is 0x100 for 8-bit parts, 0x80 for 7-bit parts.
// RULE3: write-protect input blocks every non-volatile write.
// RULE4: serial data out returns read data and shows the error flag.
// RULE5: host drives our serial data in from its own data out.
// RULE6: leaving supply reset reloads wipers, defaults terminal control, runs.
// RULE7: valid commands execute just above the supply threshold.
// RULE8: below the supply threshold, serial port off, no new EEPROM write.
// RULE9: retention loss marks volatile wipers and terminal control undefined.
// RULE10: command cut by brown-out leaves its location unguaranteed.
// RULE11: reset pin low forces defaults and reloads every volatile wiper.
// RULE12: reset pin low keeps the serial interface disabled.
// RULE13: an EEPROM write in progress completes despite reset.
// RULE14: pull-ups enabled while reset pin low or supply under threshold.
// RULE15: normal commands at normal select, high-voltage ones at high level.
// RULE16: a smart pull-up switches off while its input is driven low.
// RULE17: internal reset is supply reset OR reset pin low.
`timescale 1ns/1ps

module digipot_reset_wiper_load
  import digipot_pkg::*;
#(
  parameter bit EIGHT_BIT = 1'b1,
  parameter int WRITE_CYCLES = EE_WRITE_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // supply and reset sensing
  input wire logic supply_threshold_reset_i,
  input wire logic reset_pin_n_i,
  input wire logic ram_retention_lost_i,
  input wire logic write_protect_i,
  input wire pin_level_type pin_low_i,
  // decoded serial commands
  input wire cs_level_type cs_level_i,
  input wire logic cmd_valid_i,
  input wire serial_cmd_type cmd_i,
  input wire logic sdo_shift_i,
  // wiper and terminal state
  output logic [NUM_POTS-1:0][8:0] wiper_code_o,
  output logic [NUM_POTS-1:0] term_b_sel_o,
  output logic [NUM_POTS-1:0] term_a_sel_o,
  output logic [1:0][8:0] terminal_connect_control_o,
  output logic volatile_valid_o,
  // status and serial out
  output logic [8:0] status_o,
  output logic cmd_error_o,
  output logic sdo_o,
  output logic in_reset_o,
  output pin_level_type pullup_en_o
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  localparam logic [8:0] FULL = EIGHT_BIT ? WIPER_FULL_8BIT : WIPER_FULL_7BIT;
  localparam logic [8:0] MID = EIGHT_BIT ? WIPER_MID_8BIT : WIPER_MID_7BIT;
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  function automatic decode_type decode(input logic [3:0] addr);
    decode_type d;
    d = '{kind: K_NONE, idx: 2'd0};
    unique case (addr)
      ADDR_VOL_WIPER0: d = '{kind: K_VOL, idx: 2'd0};
      ADDR_VOL_WIPER1: d = '{kind: K_VOL, idx: 2'd1};
      ADDR_VOL_WIPER2: d = '{kind: K_VOL, idx: 2'd2};
      ADDR_VOL_WIPER3: d = '{kind: K_VOL, idx: 2'd3};
      ADDR_NV_WIPER0: d = '{kind: K_NV, idx: 2'd0};
      ADDR_NV_WIPER1: d = '{kind: K_NV, idx: 2'd1};
      ADDR_NV_WIPER2: d = '{kind: K_NV, idx: 2'd2};
      ADDR_NV_WIPER3: d = '{kind: K_NV, idx: 2'd3};
      ADDR_TCON0: d = '{kind: K_TERMINAL_CONNECT_CONTROL, idx: 2'd0};
      ADDR_TCON1: d = '{kind: K_TERMINAL_CONNECT_CONTROL, idx: 2'd1};
      ADDR_STATUS: d = '{kind: K_STATUS, idx: 2'd0};
      default: d = '{kind: K_NONE, idx: 2'd0};
    endcase
    return d;
  endfunction

  function automatic logic [8:0] clamp(input logic [8:0] v);
    return (v > FULL) ? FULL : v;
  endfunction

  typedef enum logic {EE_IDLE, EE_BUSY} ee_state_type;

  logic hw_reset;
  logic hw_reset_q_ff;
  logic accept;
  logic bad;
  decode_type dec;
  ee_state_type ee_state_ff;
  logic [CNT_W-1:0] ee_cnt_ff;
  logic [1:0] ee_idx_ff;
  logic [8:0] ee_data_ff;
  logic [NUM_POTS-1:0][8:0] nv_ff;
  logic [NUM_POTS-1:0][8:0] vol_ff;
  logic [NUM_POTS-1:0][8:0] nxt_vol;
  logic [1:0][8:0] terminal_connect_control_ff;
  logic [1:0][8:0] nxt_terminal_connect_control;
  logic [8:0] status_now;
  logic [8:0] rd_data;
  logic [8:0] sdo_shreg_ff;
  logic error_ff;

  // ------------------------------------------------------------------
  // reset combine and command gating
  // ------------------------------------------------------------------
  // RULE17 combined reset
  assign hw_reset = supply_threshold_reset_i | ~reset_pin_n_i;
  assign dec = decode(cmd_i.addr);
  // RULE8 RULE12 RULE7 port gating
  assign accept = cmd_valid_i & ~hw_reset & ~error_ff
                  & (cs_level_i != CS_IDLE);
  assign status_now = STATUS_FIXED
                      | (9'((ee_state_ff == EE_BUSY)) << STATUS_EEWA_POS);

  // RULE3 RULE15 command errors
  always_comb
  begin
    bad = 1'b0;
    if (cmd_i.hv && cs_level_i != CS_HIGH_V)
      bad = 1'b1;
    if (dec.kind == K_NONE)
      bad = 1'b1;
    if (dec.kind == K_STATUS && cmd_i.op != OP_READ)
      bad = 1'b1;
    if ((cmd_i.op == OP_INC || cmd_i.op == OP_DEC) && dec.kind != K_VOL)
      bad = 1'b1;
    if (dec.kind == K_NV && ee_state_ff == EE_BUSY)
      bad = 1'b1;
    if (dec.kind == K_NV && cmd_i.op == OP_WRITE && write_protect_i)
      bad = 1'b1;
  end

  always_comb
  begin
    unique case (dec.kind)
      K_VOL: rd_data = vol_ff[dec.idx];
      K_NV: rd_data = nv_ff[dec.idx];
      K_TERMINAL_CONNECT_CONTROL: rd_data = terminal_connect_control_ff[dec.idx[0]];
      K_STATUS: rd_data = status_now;
      default: rd_data = 9'h000;
    endcase
  end

  // ------------------------------------------------------------------
  // next volatile state
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_vol = vol_ff;
    nxt_terminal_connect_control = terminal_connect_control_ff;
    if (hw_reset)
    begin
      // RULE6 RULE11 reload and defaults
      nxt_vol = nv_ff;
      nxt_terminal_connect_control = {TERMINAL_CONNECT_CONTROL_RST, TERMINAL_CONNECT_CONTROL_RST};
    end
    else if (accept && !bad)
    begin
      if (dec.kind == K_VOL)
      begin
        unique case (cmd_i.op)
          OP_WRITE: nxt_vol[dec.idx] = clamp(cmd_i.data);
          OP_INC:
            if (vol_ff[dec.idx] < FULL)
              nxt_vol[dec.idx] = vol_ff[dec.idx] + 9'h001;
          OP_DEC:
            if (vol_ff[dec.idx] != WIPER_ZERO)
              nxt_vol[dec.idx] = vol_ff[dec.idx] - 9'h001;
          OP_READ: nxt_vol = vol_ff;
        endcase
      end
      if (dec.kind == K_TERMINAL_CONNECT_CONTROL && cmd_i.op == OP_WRITE)
        nxt_terminal_connect_control[dec.idx[0]] = cmd_i.data;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vol_ff <= '0;
      terminal_connect_control_ff <= {TERMINAL_CONNECT_CONTROL_RST, TERMINAL_CONNECT_CONTROL_RST};
    end
    else
    begin
      vol_ff <= nxt_vol;
      terminal_connect_control_ff <= nxt_terminal_connect_control;
    end
  end

  // ------------------------------------------------------------------
  // wiper end points
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      term_b_sel_o <= '0;
      term_a_sel_o <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_POTS; i++)
      begin
        // RULE1 zero scale to B
        term_b_sel_o[i] <= (nxt_vol[i] == WIPER_ZERO);
        // RULE2 full scale to A
        term_a_sel_o[i] <= (nxt_vol[i] == FULL);
      end
    end
  end

  // ------------------------------------------------------------------
  // retention tracking
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hw_reset_q_ff <= 1'b1;
      volatile_valid_o <= 1'b0;
    end
    else
    begin
      hw_reset_q_ff <= hw_reset;
      // RULE9 RULE10 contents untrusted until reload
      if (ram_retention_lost_i)
        volatile_valid_o <= 1'b0;
      else if (hw_reset_q_ff && !hw_reset)
        volatile_valid_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // non-volatile write cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ee_state_ff <= EE_IDLE;
      ee_cnt_ff <= '0;
      ee_idx_ff <= 2'd0;
      ee_data_ff <= 9'h000;
      nv_ff <= {NUM_POTS{MID}};
    end
    else
    begin
      unique case (ee_state_ff)
        EE_IDLE:
          // RULE3 RULE8 start only when allowed
          if (accept && !bad && dec.kind == K_NV && cmd_i.op == OP_WRITE)
          begin
            ee_state_ff <= EE_BUSY;
            ee_cnt_ff <= CNT_W'(WRITE_CYCLES - 1);
            ee_idx_ff <= dec.idx;
            ee_data_ff <= clamp(cmd_i.data);
          end
        EE_BUSY:
          // RULE13 runs on through reset
          if (ee_cnt_ff == '0)
          begin
            nv_ff[ee_idx_ff] <= ee_data_ff;
            ee_state_ff <= EE_IDLE;
          end
          else
            ee_cnt_ff <= ee_cnt_ff - CNT_W'(1);
      endcase
    end
  end

  // ------------------------------------------------------------------
  // error flag and serial data out
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      error_ff <= 1'b0;
    else if (accept && bad)
      error_ff <= 1'b1;
    else if (cs_level_i == CS_IDLE || hw_reset)
      error_ff <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sdo_shreg_ff <= 9'h000;
      sdo_o <= 1'b0;
    end
    else
    begin
      if (accept && !bad && cmd_i.op == OP_READ)
        sdo_shreg_ff <= rd_data;
      else if (sdo_shift_i)
        sdo_shreg_ff <= {sdo_shreg_ff[7:0], 1'b0};
      // RULE4 error holds output low
      sdo_o <= ~error_ff & sdo_shreg_ff[8];
    end
  end

  // ------------------------------------------------------------------
  // registered outputs and pull-ups
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wiper_code_o <= '0;
      terminal_connect_control_o <= {TERMINAL_CONNECT_CONTROL_RST, TERMINAL_CONNECT_CONTROL_RST};
      status_o <= STATUS_FIXED;
      cmd_error_o <= 1'b0;
      in_reset_o <= 1'b1;
      pullup_en_o <= '1;
    end
    else
    begin
      wiper_code_o <= nxt_vol;
      terminal_connect_control_o <= nxt_terminal_connect_control;
      status_o <= status_now;
      cmd_error_o <= error_ff;
      in_reset_o <= hw_reset;
      // RULE14 RULE16 pull-up control
      pullup_en_o <= hw_reset ? ~pin_low_i : '0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_zero_b;
    @(posedge clk_sys_i) disable iff (rst_i)
    (nxt_vol[0] == WIPER_ZERO) |=> term_b_sel_o[0] && !term_a_sel_o[0];
  endproperty
  a_zero_b: assert property (p_zero_b) // RULE1
    else $error("zero code not on terminal B");

  property p_full_bound;
    @(posedge clk_sys_i) disable iff (rst_i)
    (vol_ff[1] <= FULL) && (term_a_sel_o[1] == (vol_ff[1] == FULL));
  endproperty
  a_full_bound: assert property (p_full_bound) // RULE2
    else $error("wiper beyond full scale or A select wrong");

  property p_wp_block;
    @(posedge clk_sys_i) disable iff (rst_i)
    (ee_state_ff == EE_IDLE && write_protect_i) |=> ee_state_ff == EE_IDLE;
  endproperty
  a_wp_block: assert property (p_wp_block) // RULE3
    else $error("eeprom write started under write protect");

  property p_sdo_err;
    @(posedge clk_sys_i) disable iff (rst_i)
    error_ff ##1 error_ff |-> !sdo_o && cmd_error_o;
  endproperty
  a_sdo_err: assert property (p_sdo_err) // RULE4
    else $error("error not shown on serial out");

  property p_reload;
    @(posedge clk_sys_i) disable iff (rst_i)
    hw_reset |=> wiper_code_o == $past(nv_ff)
      && terminal_connect_control_o == {TERMINAL_CONNECT_CONTROL_RST, TERMINAL_CONNECT_CONTROL_RST};
  endproperty
  a_reload: assert property (p_reload) // RULE11
    else $error("reset did not reload wipers and defaults");

  property p_port_off;
    @(posedge clk_sys_i) disable iff (rst_i)
    hw_reset && ee_state_ff == EE_IDLE |=> $stable(nv_ff) && !error_ff;
  endproperty
  a_port_off: assert property (p_port_off) // RULE12
    else $error("serial traffic acted on during reset");

  property p_write_runs;
    @(posedge clk_sys_i) disable iff (rst_i)
    (ee_state_ff == EE_BUSY && ee_cnt_ff != '0 && hw_reset)
      |=> ee_state_ff == EE_BUSY && ee_cnt_ff == $past(ee_cnt_ff) - 1'b1;
  endproperty
  a_write_runs: assert property (p_write_runs) // RULE13
    else $error("eeprom write disturbed by reset");

  property p_pullup;
    @(posedge clk_sys_i) disable iff (rst_i)
    hw_reset |=> pullup_en_o == ~$past(pin_low_i);
  endproperty
  a_pullup: assert property (p_pullup) // RULE14
    else $error("pull-up state wrong in reset");

  property p_hv_err;
    @(posedge clk_sys_i) disable iff (rst_i)
    accept && cmd_i.hv && cs_level_i == CS_NORMAL |=> ##1 cmd_error_o;
  endproperty
  a_hv_err: assert property (p_hv_err) // RULE15
    else $error("high-voltage command taken at normal select");

  property p_reset_or;
    @(posedge clk_sys_i) disable iff (rst_i)
    !reset_pin_n_i || supply_threshold_reset_i |=> in_reset_o;
  endproperty
  a_reset_or: assert property (p_reset_or) // RULE17
    else $error("internal reset not formed from both sources");

  c_nv_commit: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    ee_state_ff == EE_BUSY ##1 ee_state_ff == EE_IDLE);
  c_reset_in_write: cover property (@(posedge clk_sys_i)
    disable iff (rst_i) ee_state_ff == EE_BUSY && hw_reset);
  c_inc_full: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    term_a_sel_o[0]);

endmodule

// ### host_cmd_model.sv
// host side model that issues decoded serial commands
// assumes its tasks are called from the falling clock edge
`timescale 1ns/1ps
module host_cmd_model
  import digipot_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // serial out of the block
  input wire logic sdo_i,
  // command side
  output cs_level_type cs_level_o,
  output logic cmd_valid_o,
  output serial_cmd_type cmd_o,
  output logic sdo_shift_o
);
  initial
  begin
    cs_level_o = CS_IDLE;
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    sdo_shift_o = 1'b0;
  end

  task automatic send(input cs_level_type cs, input op_type op,
    input logic [3:0] a, input logic [8:0] d, input logic hv);
    @(negedge clk_sys_i);
    cs_level_o = cs;
    cmd_valid_o = 1'b1;
    cmd_o = '{op, a, d, hv};
    @(negedge clk_sys_i);
    cmd_valid_o = 1'b0;
    // idle bus shows no stale command
    cmd_o = ~cmd_o;
  endtask

  task automatic drop_cs();
    @(negedge clk_sys_i);
    cs_level_o = CS_IDLE;
    @(negedge clk_sys_i);
  endtask

  // msb first, one bit per shift pulse
  task automatic read_word(input logic [3:0] a, output logic [8:0] w);
    send(CS_NORMAL, OP_READ, a, 9'h000, 1'b0);
    @(negedge clk_sys_i);
    w[8] = sdo_i;
    for (int i = 7; i >= 0; i--)
    begin
      sdo_shift_o = 1'b1;
      @(negedge clk_sys_i);
      sdo_shift_o = 1'b0;
      @(negedge clk_sys_i);
      w[i] = sdo_i;
    end
  endtask
endmodule

// ### tb.sv
// self-checking bench of the wiper reset and load logic
// assumes the host model above and a shortened EEPROM write time
`timescale 1ns/1ps
module tb;
  import digipot_pkg::*;
  localparam int WCYC = 6;
  typedef struct {int sel; int idx; logic [8:0] v;} note_type;
  logic clk_sys_i;
  logic rst_i;
  logic supply_threshold_reset_i;
  logic reset_pin_n_i;
  logic ram_retention_lost_i;
  logic write_protect_i;
  pin_level_type pin_low_i;
  cs_level_type cs_level_i;
  logic cmd_valid_i;
  serial_cmd_type cmd_i;
  logic sdo_shift_i;
  logic [NUM_POTS-1:0][8:0] wiper_code_o;
  logic [NUM_POTS-1:0] term_b_sel_o;
  logic [NUM_POTS-1:0] term_a_sel_o;
  logic [1:0][8:0] terminal_connect_control_o;
  logic volatile_valid_o;
  logic [8:0] status_o;
  logic cmd_error_o;
  logic sdo_o;
  logic in_reset_o;
  pin_level_type pullup_en_o;
  int mismatches;
  int n_checks;
  int seed;
  logic [8:0] rd_word;
  logic [8:0] d;
  note_type exp_q[$];

  digipot_reset_wiper_load #(.EIGHT_BIT(1'b1), .WRITE_CYCLES(WCYC)) DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .supply_threshold_reset_i(supply_threshold_reset_i),
    .reset_pin_n_i(reset_pin_n_i),
    .ram_retention_lost_i(ram_retention_lost_i),
    .write_protect_i(write_protect_i), .pin_low_i(pin_low_i),
    .cs_level_i(cs_level_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .sdo_shift_i(sdo_shift_i), .wiper_code_o(wiper_code_o),
    .term_b_sel_o(term_b_sel_o), .term_a_sel_o(term_a_sel_o),
    .terminal_connect_control_o(terminal_connect_control_o),
    .volatile_valid_o(volatile_valid_o), .status_o(status_o),
    .cmd_error_o(cmd_error_o), .sdo_o(sdo_o), .in_reset_o(in_reset_o),
    .pullup_en_o(pullup_en_o));

  host_cmd_model host (
    .clk_sys_i(clk_sys_i), .sdo_i(sdo_o), .cs_level_o(cs_level_i),
    .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .sdo_shift_o(sdo_shift_i));

  // ------------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    repeat (2) @(negedge clk_sys_i);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [8:0] pick(input int sel, input int idx);
    case (sel)
      0: return wiper_code_o[idx];
      1: return terminal_connect_control_o[idx];
      2: return status_o;
      3: return {8'h00, cmd_error_o};
      4: return rd_word;
      5: return {7'h00, term_a_sel_o[idx], term_b_sel_o[idx]};
      6: return {5'h00, pullup_en_o};
      7: return {8'h00, in_reset_o};
      default: return {8'h00, volatile_valid_o};
    endcase
  endfunction

  task automatic expect_out(input int sel, input int idx,
    input logic [8:0] v);
    exp_q.push_back('{sel, idx, v});
  endtask

  // every queued note against outputs settled before this edge
  always @(posedge clk_sys_i)
  begin
    while (exp_q.size() > 0)
    begin
      chk(pick(exp_q[0].sel, exp_q[0].idx), exp_q[0].v);
      void'(exp_q.pop_front());
    end
  end

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    n_checks = 0;
    seed = 32'hf3ea;
    rst_i = 1'b1;
    supply_threshold_reset_i = 1'b1;
    reset_pin_n_i = 1'b1;
    ram_retention_lost_i = 1'b0;
    write_protect_i = 1'b0;
    pin_low_i = pin_level_type'(4'($random(seed)));
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    expect_out(6, 0, {5'h00, ~pin_low_i});
    expect_out(7, 0, 9'h001);
    @(negedge clk_sys_i);
    supply_threshold_reset_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    for (int p = 0; p < NUM_POTS; p++)
      expect_out(0, p, WIPER_MID_8BIT);
    expect_out(1, 0, TERMINAL_CONNECT_CONTROL_RST);
    expect_out(1, 1, TERMINAL_CONNECT_CONTROL_RST);
    expect_out(6, 0, 9'h000);
    expect_out(7, 0, 9'h000);
    expect_out(8, 0, 9'h001);
    host.send(CS_NORMAL, OP_WRITE, ADDR_VOL_WIPER0, 9'h000, 1'b0);
    host.send(CS_NORMAL, OP_WRITE, ADDR_VOL_WIPER1, 9'h1FF, 1'b0);
    expect_out(0, 0, WIPER_ZERO);
    expect_out(5, 0, 9'h001);
    expect_out(0, 1, WIPER_FULL_8BIT);
    expect_out(5, 1, 9'h002);
    host.send(CS_NORMAL, OP_DEC, ADDR_VOL_WIPER0, 9'h000, 1'b0);
    host.send(CS_NORMAL, OP_INC, ADDR_VOL_WIPER1, 9'h000, 1'b0);
    expect_out(0, 0, WIPER_ZERO);
    expect_out(0, 1, WIPER_FULL_8BIT);
    d = 9'($random(seed)) & 9'h0FF;
    host.send(CS_NORMAL, OP_WRITE, ADDR_VOL_WIPER2, d, 1'b0);
    host.send(CS_NORMAL, OP_INC, ADDR_VOL_WIPER2, 9'h000, 1'b0);
    expect_out(0, 2, d + 9'h001);
    d = 9'($random(seed));
    host.send(CS_NORMAL, OP_WRITE, ADDR_TCON0, d, 1'b0);
    host.read_word(ADDR_TCON0, rd_word);
    expect_out(4, 0, d);
    host.read_word(ADDR_STATUS, rd_word);
    expect_out(4, 0, STATUS_FIXED);
    // high-voltage flag without the raised select
    host.send(CS_NORMAL, OP_WRITE, ADDR_VOL_WIPER3, 9'h011, 1'b1);
    @(negedge clk_sys_i);
    expect_out(3, 0, 9'h001);
    host.send(CS_NORMAL, OP_WRITE, ADDR_VOL_WIPER3, 9'h022, 1'b0);
    expect_out(0, 3, WIPER_MID_8BIT);
    host.drop_cs();
    @(negedge clk_sys_i);
    expect_out(3, 0, 9'h000);
    host.send(CS_HIGH_V, OP_WRITE, ADDR_VOL_WIPER3, 9'h033, 1'b1);
    expect_out(0, 3, 9'h033);
    write_protect_i = 1'b1;
    host.send(CS_NORMAL, OP_WRITE, ADDR_NV_WIPER0, 9'h055, 1'b0);
    @(negedge clk_sys_i);
    expect_out(3, 0, 9'h001);
    expect_out(2, 0, STATUS_FIXED);
    write_protect_i = 1'b0;
    host.drop_cs();
    host.send(CS_NORMAL, OP_WRITE, ADDR_NV_WIPER0, 9'h055, 1'b0);
    // busy reaches the status output one edge after the state
    @(negedge clk_sys_i);
    expect_out(2, 0, STATUS_FIXED | 9'h010);
    @(negedge clk_sys_i);
    reset_pin_n_i = 1'b0;
    host.send(CS_NORMAL, OP_WRITE, ADDR_VOL_WIPER1, 9'h011, 1'b0);
    repeat (WCYC + 4) @(negedge clk_sys_i);
    expect_out(0, 0, 9'h055);
    expect_out(0, 1, WIPER_MID_8BIT);
    expect_out(1, 0, TERMINAL_CONNECT_CONTROL_RST);
    expect_out(7, 0, 9'h001);
    @(negedge clk_sys_i);
    reset_pin_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    expect_out(2, 0, STATUS_FIXED);
    expect_out(7, 0, 9'h000);
    supply_threshold_reset_i = 1'b1;
    host.send(CS_NORMAL, OP_WRITE, ADDR_NV_WIPER1, 9'h077, 1'b0);
    @(negedge clk_sys_i);
    supply_threshold_reset_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    host.read_word(ADDR_NV_WIPER1, rd_word);
    expect_out(4, 0, WIPER_MID_8BIT);
    ram_retention_lost_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    expect_out(8, 0, 9'h000);
    ram_retention_lost_i = 1'b0;
    finish_test();
  end
endmodule
